// [design/aogm_pkg.sv]
package aogm_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register port geometry
	localparam int ADDR_W = 7;
	localparam int DATA_W = 16;
	localparam int GAIN_W = 6;
	localparam int MIX_W = 9;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [6:0] OFS_HP_LEFT_VOL = 7'h1C;
	localparam logic [6:0] OFS_HP_RIGHT_VOL = 7'h1D;
	localparam logic [6:0] OFS_SPK_MIX_ATTEN = 7'h22;
	localparam logic [6:0] OFS_SPK_OUT_SRC = 7'h24;
	localparam logic [6:0] OFS_SPK_BOOST = 7'h25;
	localparam logic [6:0] OFS_SPK_VOL = 7'h26;
	localparam logic [6:0] OFS_HP_LEFT_ROUTE = 7'h2D;
	localparam logic [6:0] OFS_HP_RIGHT_ROUTE = 7'h2E;
	localparam logic [6:0] OFS_HP_LEFT_ATTEN = 7'h2F;
	localparam logic [6:0] OFS_HP_RIGHT_ATTEN = 7'h30;

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int UPDATE_BIT = 8;
	localparam int ZERO_CROSS_BIT = 7;
	localparam int MUTE_BIT = 6;
	localparam int GAIN_MSB = 5;
	localparam int MIXER_MUTE_BIT = 8;
	localparam int SPK_SRC_BIT = 4;
	localparam int BOOST_MSB = 5;
	localparam int BOOST_LSB = 3;

	// Writable bits of the mixer words; everything else reads as zero
	localparam logic [8:0] ATTEN4_MASK = 9'h1FF;
	localparam logic [8:0] LEFT_ATTEN_MASK = 9'h1CC;
	localparam logic [8:0] LEFT_ROUTE_MASK = 9'h044;
	localparam logic [8:0] RIGHT_ROUTE_MASK = 9'h055;

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [5:0] HP_GAIN_RST = 6'h2D;
	localparam logic [5:0] SPK_GAIN_RST = 6'h39;
	localparam logic [8:0] ATTEN_RST = 9'h100;
	localparam logic [8:0] ROUTE_RST = 9'h000;
	localparam logic SPK_SRC_RST = 1'h1;
	localparam logic [2:0] BOOST_RST = 3'h0;

	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef struct packed {
		logic zc;
		logic mute;
		logic [GAIN_W-1:0] pend;
		logic [GAIN_W-1:0] gain;
		logic upd;
	} aogm_chan_t;

	typedef struct packed {
		logic [GAIN_W-1:0] hp_left_gain;
		logic hp_left_mute;
		logic [GAIN_W-1:0] hp_right_gain;
		logic hp_right_mute;
		logic [GAIN_W-1:0] spk_gain;
		logic spk_mute;
		logic [MIX_W-1:0] spk_mix_atten;
		logic spk_src_en;
		logic [2:0] spk_boost;
		logic [MIX_W-1:0] left_route;
		logic [MIX_W-1:0] right_route;
		logic [MIX_W-1:0] left_atten;
		logic [MIX_W-1:0] right_atten;
	} aogm_ctrl_t;

endpackage : aogm_pkg

// [design/aogm_regs.sv]
// Functional notes
// - Headphone update bit applies both channel volumes together.
// - Right headphone zero-cross bit defers gain changes.
// - Left headphone zero-cross bit defers gain changes.
// - Right headphone mute bit six, resets unmuted.
// - Headphone gains six bits, reset 10_1101.
// - Two-bit attenuation codes 0/-6/-9/-12 dB, reset 00.
// - Speaker mixer attenuation holds four input fields.
// - Speaker mixer-to-output enable bit four, resets one.
// - Speaker boost code bits 5:3, reset 000.
// - Speaker update bit applies pending speaker volume.
// - Speaker zero-cross bit defers gain changes.
// - Speaker mute bit six, resets unmuted.
// - Speaker gain six bits, reset 11_1001.
// - Left mixer routes inputs one A, two A.
// - Right mixer routes all four inputs.
// - Left mixer attenuation fields at 7:6, 3:2.
// - Right mixer attenuation four fields at 7:0.
`timescale 1ns/1ns
`default_nettype none

module aogm_regs #(
	parameter int ADDR_W = aogm_pkg::ADDR_W
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Register port, one access per strobe cycle
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [aogm_pkg::DATA_W-1:0] reg_wdata_i,
	output var logic [aogm_pkg::DATA_W-1:0] reg_rdata_o,
	output var logic reg_ack_o,
	// Zero-crossing pulses from the analogue paths
	input wire logic zc_hp_left_i,
	input wire logic zc_hp_right_i,
	input wire logic zc_spk_i,
	// Control word toward the analogue paths
	output var aogm_pkg::aogm_ctrl_t ctrl_o
);

	////////////////////////////////////////////////////////////////////////////
	// Elaboration check

	if (ADDR_W < 7) begin : g_bad_addr
		$error("aogm_regs: ADDR_W must cover the register offsets");
	end

	////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		aogm_pkg::aogm_chan_t hpl;
		aogm_pkg::aogm_chan_t hpr;
		aogm_pkg::aogm_chan_t spk;
		logic [aogm_pkg::MIX_W-1:0] spk_atten;
		logic spk_src;
		logic [2:0] boost;
		logic [aogm_pkg::MIX_W-1:0] lroute;
		logic [aogm_pkg::MIX_W-1:0] rroute;
		logic [aogm_pkg::MIX_W-1:0] latten;
		logic [aogm_pkg::MIX_W-1:0] ratten;
		logic [aogm_pkg::DATA_W-1:0] rdata;
		logic ack;
	} aogm_state_t;

	aogm_state_t s;
	aogm_state_t next_s;
	logic [6:0] addr;
	logic [aogm_pkg::DATA_W-1:0] wd;

	assign addr = reg_addr_i[6:0];
	assign wd = reg_wdata_i;

	// A pending gain moves to the output at once, or on the next crossing
	function automatic aogm_pkg::aogm_chan_t apply_gain(
		input aogm_pkg::aogm_chan_t c,
		input logic zc_pulse
	);
		aogm_pkg::aogm_chan_t r;
		r = c;
		if (c.upd && (!c.zc || zc_pulse)) begin
			r.gain = c.pend;
			r.upd = 1'b0;
		end
		return r;
	endfunction : apply_gain

	// Read image of a volume register; the update bit always reads zero
	function automatic logic [aogm_pkg::DATA_W-1:0] vol_word(
		input aogm_pkg::aogm_chan_t c
	);
		logic [aogm_pkg::DATA_W-1:0] w;
		w = '0;
		w[aogm_pkg::ZERO_CROSS_BIT] = c.zc;
		w[aogm_pkg::MUTE_BIT] = c.mute;
		w[aogm_pkg::GAIN_MSB:0] = c.pend;
		return w;
	endfunction : vol_word

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_s = s;
		next_s.ack = reg_wr_i || reg_rd_i;
		next_s.hpl = apply_gain(s.hpl, zc_hp_left_i);
		next_s.hpr = apply_gain(s.hpr, zc_hp_right_i);
		next_s.spk = apply_gain(s.spk, zc_spk_i);
		// Writes come after the apply step so a fresh update request wins
		if (reg_wr_i) begin
			case (addr)
				aogm_pkg::OFS_HP_LEFT_VOL: begin
					next_s.hpl.zc = wd[aogm_pkg::ZERO_CROSS_BIT];
					next_s.hpl.mute = wd[aogm_pkg::MUTE_BIT];
					next_s.hpl.pend = wd[aogm_pkg::GAIN_MSB:0];
					if (wd[aogm_pkg::UPDATE_BIT]) begin
						next_s.hpl.upd = 1'b1;
						next_s.hpr.upd = 1'b1;
					end
				end
				aogm_pkg::OFS_HP_RIGHT_VOL: begin
					next_s.hpr.zc = wd[aogm_pkg::ZERO_CROSS_BIT];
					next_s.hpr.mute = wd[aogm_pkg::MUTE_BIT];
					next_s.hpr.pend = wd[aogm_pkg::GAIN_MSB:0];
					if (wd[aogm_pkg::UPDATE_BIT]) begin
						next_s.hpl.upd = 1'b1;
						next_s.hpr.upd = 1'b1;
					end
				end
				aogm_pkg::OFS_SPK_MIX_ATTEN: begin
					next_s.spk_atten = wd[8:0] & aogm_pkg::ATTEN4_MASK;
				end
				aogm_pkg::OFS_SPK_OUT_SRC: begin
					next_s.spk_src = wd[aogm_pkg::SPK_SRC_BIT];
				end
				aogm_pkg::OFS_SPK_BOOST: begin
					next_s.boost = wd[aogm_pkg::BOOST_MSB:aogm_pkg::BOOST_LSB];
				end
				aogm_pkg::OFS_SPK_VOL: begin
					next_s.spk.zc = wd[aogm_pkg::ZERO_CROSS_BIT];
					next_s.spk.mute = wd[aogm_pkg::MUTE_BIT];
					next_s.spk.pend = wd[aogm_pkg::GAIN_MSB:0];
					if (wd[aogm_pkg::UPDATE_BIT]) begin
						next_s.spk.upd = 1'b1;
					end
				end
				aogm_pkg::OFS_HP_LEFT_ROUTE: begin
					next_s.lroute = wd[8:0] & aogm_pkg::LEFT_ROUTE_MASK;
				end
				aogm_pkg::OFS_HP_RIGHT_ROUTE: begin
					next_s.rroute = wd[8:0] & aogm_pkg::RIGHT_ROUTE_MASK;
				end
				aogm_pkg::OFS_HP_LEFT_ATTEN: begin
					next_s.latten = wd[8:0] & aogm_pkg::LEFT_ATTEN_MASK;
				end
				aogm_pkg::OFS_HP_RIGHT_ATTEN: begin
					next_s.ratten = wd[8:0] & aogm_pkg::ATTEN4_MASK;
				end
				default: begin
				end
			endcase
		end
		// Reads see the registers as they stood before this cycle's write
		if (reg_rd_i) begin
			case (addr)
				aogm_pkg::OFS_HP_LEFT_VOL: next_s.rdata = vol_word(s.hpl);
				aogm_pkg::OFS_HP_RIGHT_VOL: next_s.rdata = vol_word(s.hpr);
				aogm_pkg::OFS_SPK_VOL: next_s.rdata = vol_word(s.spk);
				aogm_pkg::OFS_SPK_MIX_ATTEN: next_s.rdata = {7'h00, s.spk_atten};
				aogm_pkg::OFS_SPK_OUT_SRC: next_s.rdata = {11'h000, s.spk_src, 4'h0};
				aogm_pkg::OFS_SPK_BOOST: next_s.rdata = {10'h000, s.boost, 3'h0};
				aogm_pkg::OFS_HP_LEFT_ROUTE: next_s.rdata = {7'h00, s.lroute};
				aogm_pkg::OFS_HP_RIGHT_ROUTE: next_s.rdata = {7'h00, s.rroute};
				aogm_pkg::OFS_HP_LEFT_ATTEN: next_s.rdata = {7'h00, s.latten};
				aogm_pkg::OFS_HP_RIGHT_ATTEN: next_s.rdata = {7'h00, s.ratten};
				default: next_s.rdata = 16'h0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= '0;
			s.hpl.pend <= aogm_pkg::HP_GAIN_RST;
			s.hpl.gain <= aogm_pkg::HP_GAIN_RST;
			s.hpr.pend <= aogm_pkg::HP_GAIN_RST;
			s.hpr.gain <= aogm_pkg::HP_GAIN_RST;
			s.spk.pend <= aogm_pkg::SPK_GAIN_RST;
			s.spk.gain <= aogm_pkg::SPK_GAIN_RST;
			s.spk_atten <= aogm_pkg::ATTEN_RST;
			s.latten <= aogm_pkg::ATTEN_RST;
			s.ratten <= aogm_pkg::ATTEN_RST;
			s.lroute <= aogm_pkg::ROUTE_RST;
			s.rroute <= aogm_pkg::ROUTE_RST;
			s.spk_src <= aogm_pkg::SPK_SRC_RST;
			s.boost <= aogm_pkg::BOOST_RST;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign reg_rdata_o = s.rdata;
	assign reg_ack_o = s.ack;
	always_comb begin
		ctrl_o.hp_left_gain = s.hpl.gain;
		ctrl_o.hp_left_mute = s.hpl.mute;
		ctrl_o.hp_right_gain = s.hpr.gain;
		ctrl_o.hp_right_mute = s.hpr.mute;
		ctrl_o.spk_gain = s.spk.gain;
		ctrl_o.spk_mute = s.spk.mute;
		ctrl_o.spk_mix_atten = s.spk_atten;
		ctrl_o.spk_src_en = s.spk_src;
		ctrl_o.spk_boost = s.boost;
		ctrl_o.left_route = s.lroute;
		ctrl_o.right_route = s.rroute;
		ctrl_o.left_atten = s.latten;
		ctrl_o.right_atten = s.ratten;
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence hp_vu_now;
		reg_wr_i && addr == aogm_pkg::OFS_HP_LEFT_VOL && wd[aogm_pkg::UPDATE_BIT]
			&& !wd[aogm_pkg::ZERO_CROSS_BIT] && !s.hpr.zc;
	endsequence

	sequence quiet_port;
		!reg_wr_i;
	endsequence

	sequence spk_vu_now;
		reg_wr_i && addr == aogm_pkg::OFS_SPK_VOL && wd[aogm_pkg::UPDATE_BIT]
			&& !wd[aogm_pkg::ZERO_CROSS_BIT];
	endsequence

	sequence hpr_vu_now;
		reg_wr_i && addr == aogm_pkg::OFS_HP_RIGHT_VOL && wd[aogm_pkg::UPDATE_BIT]
			&& !wd[aogm_pkg::ZERO_CROSS_BIT] && !s.hpl.zc;
	endsequence

	AST_HP_VU_TOGETHER: assert property (
		hp_vu_now ##1 quiet_port |-> ##1
			(s.hpl.gain == $past(wd[5:0], 2) && s.hpr.gain == $past(s.hpr.pend, 1)))
		else $error("headphone gains not applied together");

	AST_HP_RIGHT_ZC_HOLD: assert property (
		s.hpr.upd && s.hpr.zc && !zc_hp_right_i |=> $stable(s.hpr.gain))
		else $error("right headphone gain changed without a crossing");

	AST_HP_LEFT_ZC_HOLD: assert property (
		s.hpl.upd && s.hpl.zc && !zc_hp_left_i |=> $stable(s.hpl.gain))
		else $error("left headphone gain changed without a crossing");

	AST_HP_RIGHT_MUTE: assert property (
		reg_wr_i && addr == aogm_pkg::OFS_HP_RIGHT_VOL
			|=> ctrl_o.hp_right_mute == $past(wd[aogm_pkg::MUTE_BIT]))
		else $error("right headphone mute not taken");

	AST_RESET_GAINS: assert property (
		$rose(rst_n_i) |-> s.hpl.gain == aogm_pkg::HP_GAIN_RST
			&& s.hpr.gain == aogm_pkg::HP_GAIN_RST && s.spk.gain == aogm_pkg::SPK_GAIN_RST)
		else $error("gain reset value wrong");

	AST_SPK_ATTEN_READBACK: assert property (
		reg_wr_i && addr == aogm_pkg::OFS_SPK_MIX_ATTEN ##1 quiet_port ##1
			reg_rd_i && addr == aogm_pkg::OFS_SPK_MIX_ATTEN && !reg_wr_i
			|=> reg_ack_o && reg_rdata_o[8:0] == $past(wd[8:0], 3))
		else $error("speaker mixer attenuation readback wrong");

	AST_SRC_READ: assert property (
		reg_rd_i && addr == aogm_pkg::OFS_SPK_OUT_SRC
			|=> reg_rdata_o[aogm_pkg::SPK_SRC_BIT] == $past(ctrl_o.spk_src_en))
		else $error("speaker source bit reads wrong");

	AST_BOOST_WRITE: assert property (
		reg_wr_i && addr == aogm_pkg::OFS_SPK_BOOST
			|=> ctrl_o.spk_boost == $past(wd[5:3]))
		else $error("boost code not taken");

	AST_SPK_VU: assert property (
		spk_vu_now ##1 quiet_port |-> ##1 ctrl_o.spk_gain == $past(wd[5:0], 2))
		else $error("speaker gain not applied after update");

	AST_VU_READS_ZERO: assert property (
		reg_rd_i && (addr == aogm_pkg::OFS_HP_LEFT_VOL || addr == aogm_pkg::OFS_SPK_VOL)
			|=> !reg_rdata_o[aogm_pkg::UPDATE_BIT])
		else $error("update bit reads back set");

	AST_PEND_NO_EFFECT: assert property (
		reg_wr_i && addr == aogm_pkg::OFS_SPK_VOL && !wd[aogm_pkg::UPDATE_BIT] && !s.spk.upd
			|=> $stable(ctrl_o.spk_gain))
		else $error("speaker gain moved without update");

	AST_HPR_VU_TOGETHER: assert property (
		hpr_vu_now ##1 quiet_port |-> ##1
			(s.hpr.gain == $past(wd[aogm_pkg::GAIN_MSB:0], 2)
			&& s.hpl.gain == $past(s.hpl.pend, 1)))
		else $error("headphone gains not applied together after right update");

	AST_SPK_ZC_HOLD: assert property (
		s.spk.upd && s.spk.zc && !zc_spk_i |=> $stable(ctrl_o.spk_gain))
		else $error("speaker gain changed without a crossing");

	AST_SPK_MUTE: assert property (
		reg_wr_i && addr == aogm_pkg::OFS_SPK_VOL
			|=> ctrl_o.spk_mute == $past(wd[aogm_pkg::MUTE_BIT]))
		else $error("speaker mute not taken");

	AST_LEFT_ROUTE: assert property (
		reg_wr_i && addr == aogm_pkg::OFS_HP_LEFT_ROUTE
			|=> ctrl_o.left_route == ($past(wd[aogm_pkg::MIX_W-1:0]) & aogm_pkg::LEFT_ROUTE_MASK))
		else $error("left mixer routing not taken");

	AST_RIGHT_ROUTE: assert property (
		reg_wr_i && addr == aogm_pkg::OFS_HP_RIGHT_ROUTE
			|=> ctrl_o.right_route == ($past(wd[aogm_pkg::MIX_W-1:0]) & aogm_pkg::RIGHT_ROUTE_MASK))
		else $error("right mixer routing not taken");

	AST_LEFT_ATTEN: assert property (
		reg_wr_i && addr == aogm_pkg::OFS_HP_LEFT_ATTEN
			|=> ctrl_o.left_atten == ($past(wd[aogm_pkg::MIX_W-1:0]) & aogm_pkg::LEFT_ATTEN_MASK))
		else $error("left mixer attenuation not taken");

	AST_RIGHT_ATTEN: assert property (
		reg_wr_i && addr == aogm_pkg::OFS_HP_RIGHT_ATTEN
			|=> ctrl_o.right_atten == ($past(wd[aogm_pkg::MIX_W-1:0]) & aogm_pkg::ATTEN4_MASK))
		else $error("right mixer attenuation not taken");

	// Checked at the first edge after release, before any write can land
	AST_RESET_MIXER: assert property (
		$rose(rst_n_i) |-> ctrl_o.spk_mix_atten == aogm_pkg::ATTEN_RST
			&& ctrl_o.left_atten == aogm_pkg::ATTEN_RST
			&& ctrl_o.right_atten == aogm_pkg::ATTEN_RST
			&& ctrl_o.spk_src_en && ctrl_o.spk_boost == aogm_pkg::BOOST_RST)
		else $error("mixer reset value wrong");

endmodule : aogm_regs

`default_nettype wire

// [tb/audio_output_gain_mixer_regs_tb.sv]
`timescale 1ns/1ns
`default_nettype none

module audio_output_gain_mixer_regs_tb;
	typedef struct {logic chk; logic [15:0] exp; string nm;} aogm_note_t;
	logic ref_clk_i, rst_n_i, wr, rd;
	logic [6:0] addr;
	logic [15:0] wdata, rdata, d;
	logic ack;
	logic [2:0] zc_v;
	aogm_pkg::aogm_ctrl_t ctrl;
	aogm_note_t q[$];
	aogm_note_t n;
	integer miscompares = 0, cmp_count = 0, cycles = 0;
	int seed = 32'h407A43E9;
	logic [6:0] ra[10];
	logic [15:0] rst_v[10], msk[10];

	aogm_regs i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_ack_o(ack),
		.zc_hp_left_i(zc_v[0]), .zc_hp_right_i(zc_v[1]), .zc_spk_i(zc_v[2]), .ctrl_o(ctrl));

	initial begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end

	////////////////////////////////////////////////////////////////////////////
	task compare(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : compare

	task complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run

	// Strobes are one cycle wide, so each access leaves the port idle for one cycle
	task access(input logic w, input logic [6:0] a, input logic [15:0] v, input string nm);
		@(posedge ref_clk_i);
		#1;
		wr = w;
		rd = ~w;
		addr = a;
		wdata = v;
		q.push_back('{~w, v, nm});
		@(posedge ref_clk_i);
		#1;
		wr = 1'b0;
		rd = 1'b0;
	endtask : access

	task wt(input int k);
		repeat (k) @(posedge ref_clk_i);
		#1;
	endtask : wt

	task zc_pulse(input int k);
		@(posedge ref_clk_i);
		#1;
		zc_v[k] = 1'b1;
		@(posedge ref_clk_i);
		#1;
		zc_v[k] = 1'b0;
	endtask : zc_pulse

	function automatic logic [15:0] ctl(input int i);
		case (i)
			0: ctl = 16'(ctrl.hp_left_gain);
			1: ctl = 16'(ctrl.hp_right_gain);
			2: ctl = 16'(ctrl.spk_mix_atten);
			3: ctl = 16'({ctrl.spk_src_en, 4'h0});
			4: ctl = 16'({ctrl.spk_boost, 3'h0});
			5: ctl = 16'(ctrl.spk_gain);
			6: ctl = 16'(ctrl.left_route);
			7: ctl = 16'(ctrl.right_route);
			8: ctl = 16'(ctrl.left_atten);
			default: ctl = 16'(ctrl.right_atten);
		endcase
	endfunction : ctl

	task chk_reset();
		for (int i = 0; i < 10; i++) begin
			compare("ctrl reset", rst_v[i], ctl(i));
			access(1'b0, ra[i], rst_v[i], "reset read");
		end
		compare("mutes reset", 16'h0, 16'({ctrl.hp_right_mute, ctrl.spk_mute}));
	endtask : chk_reset

	////////////////////////////////////////////////////////////////////////////
	// Read data is checked one cycle after each strobe, against the oldest note
	always @(negedge ref_clk_i) begin
		cycles++;
		if (ack === 1'b1) begin
			if (q.size() == 0) begin
				compare("ack without access", 16'h0, 16'h1);
			end else begin
				n = q.pop_front();
				if (n.chk)
					compare(n.nm, n.exp, rdata);
			end
		end
		if (cycles == 4000) begin
			miscompares++;
			complete_run();
		end
	end

	initial begin
		ra = '{aogm_pkg::OFS_HP_LEFT_VOL, aogm_pkg::OFS_HP_RIGHT_VOL, aogm_pkg::OFS_SPK_MIX_ATTEN,
			aogm_pkg::OFS_SPK_OUT_SRC, aogm_pkg::OFS_SPK_BOOST, aogm_pkg::OFS_SPK_VOL,
			aogm_pkg::OFS_HP_LEFT_ROUTE, aogm_pkg::OFS_HP_RIGHT_ROUTE,
			aogm_pkg::OFS_HP_LEFT_ATTEN, aogm_pkg::OFS_HP_RIGHT_ATTEN};
		rst_v = '{16'h002D, 16'h002D, 16'h0100, 16'h0010, 16'h0000, 16'h0039, 16'h0000,
			16'h0000, 16'h0100, 16'h0100};
		msk = '{16'h00FF, 16'h00FF, 16'h01FF, 16'h0010, 16'h0038, 16'h00FF, 16'h0044,
			16'h0055, 16'h01CC, 16'h01FF};
		rst_n_i = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 7'h00;
		wdata = 16'h0000;
		zc_v = 3'h0;
		repeat (10) @(posedge ref_clk_i);
		#1;
		rst_n_i = 1'b1;
		chk_reset();
		// Volume words carry no update here, so applied gains must stay at reset
		for (int r = 0; r < 3; r++) begin
			for (int i = 0; i < 10; i++) begin
				d = 16'($random(seed));
				if (msk[i] == 16'h00FF)
					d[8:7] = 2'h0;
				access(1'b1, ra[i], d, "");
				access(1'b0, ra[i], d & msk[i], "rw read");
				compare("ctrl", (msk[i] == 16'h00FF) ? rst_v[i] : d & msk[i], ctl(i));
				if (i < 2)
					compare("hp mute", 16'(d[6]), 16'(i ? ctrl.hp_right_mute : ctrl.hp_left_mute));
			end
		end
		access(1'b1, 7'h1C, 16'h0110, "");
		access(1'b1, 7'h1D, 16'h0120, "");
		wt(2);
		compare("hp gains", 16'h1020, {ctrl.hp_left_gain, 2'h0, ctrl.hp_right_gain});
		access(1'b0, 7'h1D, 16'h0020, "update readback");
		access(1'b1, 7'h1D, 16'h018A, "");
		wt(4);
		compare("hpr held", 16'h0020, 16'(ctrl.hp_right_gain));
		zc_pulse(1);
		wt(2);
		compare("hpr zc", 16'h000A, 16'(ctrl.hp_right_gain));
		access(1'b1, 7'h1C, 16'h0085, "");
		access(1'b1, 7'h1D, 16'h0100, "");
		wt(4);
		compare("hpl held", 16'h1000, {ctrl.hp_left_gain, 2'h0, ctrl.hp_right_gain});
		zc_pulse(0);
		wt(2);
		compare("hpl zc", 16'h0005, 16'(ctrl.hp_left_gain));
		access(1'b1, 7'h26, 16'h0105, "");
		wt(2);
		compare("spk gain", 16'h0005, 16'(ctrl.spk_gain));
		access(1'b1, 7'h26, 16'h0047, "");
		wt(1);
		compare("spk mute", 16'h0045, 16'({ctrl.spk_mute, ctrl.spk_gain}));
		access(1'b1, 7'h26, 16'h0187, "");
		wt(4);
		compare("spk held", 16'h0005, 16'(ctrl.spk_gain));
		zc_pulse(2);
		wt(2);
		compare("spk zc", 16'h0007, 16'({ctrl.spk_mute, ctrl.spk_gain}));
		for (int k = 0; k < 8; k++) begin
			access(1'b1, 7'h25, 16'(k << 3), "");
			wt(1);
			compare("boost", 16'(k), 16'(ctrl.spk_boost));
		end
		access(1'b1, 7'h23, 16'hFFFF, "");
		access(1'b0, 7'h23, 16'h0000, "unmapped read");
		// A second reset in mid-run must restore every documented default
		@(posedge ref_clk_i);
		#1;
		rst_n_i = 1'b0;
		wt(2);
		rst_n_i = 1'b1;
		chk_reset();
		wt(3);
		compare("notes left", 16'h0, 16'(q.size()));
		complete_run();
	end
endmodule : audio_output_gain_mixer_regs_tb

`default_nettype wire
